// >>> core/sertgt_top.v
// two-wire serial eeprom target: protocol engine and program cycle
`timescale 1ns/100ps
`include "sertgt_consts.vh"
// Operation
// - data changes only while clock low
// - falling data with clock high is start
// - rising data with clock high is stop
// - acknowledge each received byte on ninth clock
// - standby at reset and after stop
// - device address starts with 1010 pattern
// - three page bits are word address msbs
// - last address bit selects read or write
// - ack on match, release line on mismatch
// - byte write: address, data, stop
// - stop after write starts timed program
// - page write up to sixteen bytes
// - write wraps within page low bits
// - no ack while programming, poll allowed
// - counter holds last address plus one
// - current read sends byte at counter; here the device address page bits first replace the counter's top three bits
// - random read uses dummy write first
// - sequential read continues while master acks
// - sample on rising, drive after falling clock
// - write protect blocks all array writes
// - 128 pages of 16 bytes, 11 bits
module sertgt_top #(
	parameter AW = `SERTGT_ADDR_W,
	parameter TWR_CYC = `SERTGT_TWR_CYC
) (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// serial bus
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	// write protect strap
	input wire wp_i,
	// status
	output reg busy_o
);
	localparam PB = `SERTGT_PAGE_BITS;
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_DEV = 3'd1;
	localparam [2:0] ST_WADDR = 3'd2;
	localparam [2:0] ST_WDATA = 3'd3;
	localparam [2:0] ST_RDATA = 3'd4;
	localparam [2:0] ST_RACK = 3'd5;
	localparam [2:0] ST_PROG = 3'd6;
	// program counter sized from the program time, so a long cycle cannot wrap it
	function integer cnt_bits;
		input integer v;
		integer k;
		begin
			cnt_bits = 1;
			for (k = v; k > 1; k = k >> 1) begin
				cnt_bits = cnt_bits + 1;
			end
		end
	endfunction
	localparam CW = cnt_bits(TWR_CYC);
	localparam [31:0] TWR_LAST_W = TWR_CYC - 1;
	localparam [CW-1:0] TWR_LAST = TWR_LAST_W[CW-1:0];

	// ----------------------------------------
	// pin edges
	// ----------------------------------------
	reg scl_d_ff;
	reg sda_d_ff;
	wire scl_rise = scl_i & ~scl_d_ff;
	wire scl_fall = ~scl_i & scl_d_ff;
	wire start_det = scl_i & scl_d_ff & sda_d_ff & ~sda_i;
	wire stop_det = scl_i & scl_d_ff & ~sda_d_ff & sda_i;

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [2:0] state_ff;
	reg [3:0] bit_cnt_ff;
	reg [7:0] shift_ff;
	reg [AW-1:0] addr_ff;
	reg [AW-1:0] page_base_ff;
	reg [PB-1:0] wr_idx_ff;
	reg [PB-1:0] prog_idx_ff;
	reg [CW-1:0] prog_cnt_ff;
	reg pend_ff;
	reg ack_ph_ff;
	reg match_ff;
	reg [7:0] tx_ff;
	reg need_load_ff;
	reg load_wait_ff;

	wire [7:0] rd_data;
	wire [7:0] pb_data;
	wire pb_valid;
	wire [7:0] rx_byte = {shift_ff[6:0], sda_i};
	reg pb_wr;
	reg pb_clr;
	wire [AW-1:0] mem_wr_addr = {page_base_ff[AW-1:PB], prog_idx_ff};
	// page drains one slot per cycle, so the program time must be at least 16
	// cycles; protect is looked at while it drains, not while bytes arrive
	wire mem_wr = (state_ff == ST_PROG) && pb_valid && ~wp_i;

	sertgt_mem #(
		.AW(AW),
		.DEPTH(`SERTGT_DEPTH)
	) u_mem (
		.sys_clk_i(sys_clk_i),
		.wr_en_i(mem_wr),
		.wr_addr_i(mem_wr_addr),
		.wr_data_i(pb_data),
		.rd_addr_i(addr_ff),
		.rd_data_o(rd_data)
	);

	sertgt_pagebuf #(
		.PB(PB)
	) u_pagebuf (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.clr_i(pb_clr),
		.wr_i(pb_wr),
		.wr_idx_i(wr_idx_ff),
		.wr_data_i(rx_byte),
		.rd_idx_i(prog_idx_ff),
		.rd_data_o(pb_data),
		.rd_valid_o(pb_valid)
	);

	// ----------------------------------------
	// read prefetch
	// ----------------------------------------
	// array read is registered: the byte lands two cycles after the
	// address moves on the eighth rising clock, well before the fall after the ninth clock first drives it
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			load_wait_ff <= 1'b0;
			tx_ff <= 8'h00;
		end else begin
			load_wait_ff <= need_load_ff;
			if (load_wait_ff) begin
				tx_ff <= rd_data;
			end
		end
	end

	// ----------------------------------------
	// protocol engine
	// ----------------------------------------
	wire byte_done = scl_rise && bit_cnt_ff == 4'd7 && !ack_ph_ff;

	always @* begin
		pb_wr = 1'b0;
		pb_clr = 1'b0;
		if (state_ff == ST_WDATA && byte_done) begin
			pb_wr = 1'b1;
		end
		if (state_ff == ST_PROG && prog_cnt_ff == TWR_LAST) begin
			pb_clr = 1'b1;
		end
	end

	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			addr_ff <= {AW{1'b0}};
			page_base_ff <= {AW{1'b0}};
			wr_idx_ff <= {PB{1'b0}};
			prog_idx_ff <= {PB{1'b0}};
			prog_cnt_ff <= {CW{1'b0}};
			pend_ff <= 1'b0;
			ack_ph_ff <= 1'b0;
			match_ff <= 1'b0;
			need_load_ff <= 1'b0;
			sda_o <= 1'b1;
			sda_oe_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			scl_d_ff <= scl_i;
			sda_d_ff <= sda_i;
			busy_o <= (state_ff == ST_PROG);
			need_load_ff <= 1'b0;
			if (state_ff == ST_PROG) begin
				// inputs ignored during program cycle
				sda_oe_o <= 1'b0;
				prog_idx_ff <= prog_idx_ff + 1'b1;
				if (prog_cnt_ff == TWR_LAST) begin
					state_ff <= ST_IDLE;
					prog_cnt_ff <= {CW{1'b0}};
				end else begin
					prog_cnt_ff <= prog_cnt_ff + 1'b1;
				end
			end else if (start_det) begin
				state_ff <= ST_DEV;
				bit_cnt_ff <= 4'h0;
				ack_ph_ff <= 1'b0;
				sda_oe_o <= 1'b0;
			end else if (stop_det) begin
				sda_oe_o <= 1'b0;
				if (pend_ff) begin
					state_ff <= ST_PROG;
					pend_ff <= 1'b0;
					prog_idx_ff <= {PB{1'b0}};
				end else begin
					state_ff <= ST_IDLE;
				end
			end else if (state_ff != ST_IDLE) begin
				if (scl_rise) begin
					if (ack_ph_ff) begin
						// ninth clock: master's ack on a read
						if (state_ff == ST_RACK) begin
							if (sda_i) begin
								state_ff <= ST_IDLE;
							end else begin
								state_ff <= ST_RDATA;
								ack_ph_ff <= 1'b0;
							end
						end
					end else if (state_ff == ST_RDATA) begin
						bit_cnt_ff <= bit_cnt_ff + 1'b1;
						if (bit_cnt_ff == 4'd7) begin
							state_ff <= ST_RACK;
							ack_ph_ff <= 1'b1;
							addr_ff <= addr_ff + 1'b1;
							need_load_ff <= 1'b1;
						end
					end else begin
						shift_ff <= rx_byte;
						bit_cnt_ff <= bit_cnt_ff + 1'b1;
						if (bit_cnt_ff == 4'd7) begin
							ack_ph_ff <= 1'b1;
							case (state_ff)
							ST_DEV: begin
								match_ff <= rx_byte[7:4] == `SERTGT_TYPE_CODE;
								// a foreign address must leave the counter alone
								if (rx_byte[7:4] == `SERTGT_TYPE_CODE) begin
									addr_ff[AW-1:8] <= rx_byte[3:1];
								end
								if (!rx_byte[0]) begin
									need_load_ff <= 1'b0;
								end else begin
									need_load_ff <= 1'b1;
								end
							end
							ST_WADDR: begin
								addr_ff[7:0] <= rx_byte;
								page_base_ff <= {addr_ff[AW-1:8], rx_byte};
								wr_idx_ff <= rx_byte[PB-1:0];
							end
							ST_WDATA: begin
								pend_ff <= 1'b1;
								wr_idx_ff <= wr_idx_ff + 1'b1;
								addr_ff[PB-1:0] <= addr_ff[PB-1:0] + 1'b1;
							end
							default: begin
								state_ff <= ST_IDLE;
							end
							endcase
						end
					end
				end else if (scl_fall) begin
					// outputs change only after falling clock
					if (ack_ph_ff && bit_cnt_ff == 4'd8) begin
						if (state_ff == ST_DEV && !match_ff) begin
							sda_oe_o <= 1'b0;
							state_ff <= ST_IDLE;
							ack_ph_ff <= 1'b0;
						end else if (state_ff == ST_RACK) begin
							sda_oe_o <= 1'b0;
							bit_cnt_ff <= 4'h0;
						end else begin
							sda_o <= 1'b0;
							sda_oe_o <= 1'b1;
							bit_cnt_ff <= 4'd9;
						end
					end else if (bit_cnt_ff == 4'd9) begin
						// end of acknowledge slot
						bit_cnt_ff <= 4'h0;
						ack_ph_ff <= 1'b0;
						if (state_ff == ST_DEV) begin
							state_ff <= shift_ff[0] ? ST_RDATA : ST_WADDR;
						end else if (state_ff == ST_WADDR) begin
							state_ff <= ST_WDATA;
						end
						if (state_ff == ST_DEV && shift_ff[0]) begin
							sda_o <= tx_ff[7];
							sda_oe_o <= ~tx_ff[7];
						end else begin
							sda_oe_o <= 1'b0;
						end
					end else if (state_ff == ST_RDATA && !ack_ph_ff) begin
						// bit_cnt bits already sent; next bit msb first
						if (bit_cnt_ff == 4'd0) begin
							sda_oe_o <= ~tx_ff[7];
						end else begin
							sda_oe_o <= ~tx_ff[3'd7 - bit_cnt_ff[2:0]];
						end
						sda_o <= 1'b0;
					end
				end
			end
		end
	end
endmodule

// >>> core/sertgt_consts.vh
// constants for the two-wire serial eeprom target
`ifndef SERTGT_CONSTS_VH
`define SERTGT_CONSTS_VH
`define SERTGT_TYPE_CODE 4'hA
`define SERTGT_ADDR_W 11
`define SERTGT_PAGE_BITS 4
`define SERTGT_DEPTH 2048
`define SERTGT_CLK_PERIOD_NS 10
`define SERTGT_TWR_MS 5
`define SERTGT_TWR_CYC ((`SERTGT_TWR_MS * 1000000) / `SERTGT_CLK_PERIOD_NS)
`endif

// >>> core/sertgt_mem.v
// byte-wide array with registered read data
`timescale 1ns/100ps
module sertgt_mem #(
	parameter AW = 11,
	parameter DEPTH = 2048
) (
	// clock
	input wire sys_clk_i,
	// write port
	input wire wr_en_i,
	input wire [AW-1:0] wr_addr_i,
	input wire [7:0] wr_data_i,
	// read port
	input wire [AW-1:0] rd_addr_i,
	output reg [7:0] rd_data_o
);
	reg [7:0] mem [0:DEPTH-1];
	always @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

// >>> core/sertgt_pagebuf.v
// page write buffer with per-byte valid flags
`timescale 1ns/100ps
module sertgt_pagebuf #(
	parameter PB = 4
) (
	// clock and reset
	input wire sys_clk_i,
	input wire rst_i,
	// fill side
	input wire clr_i,
	input wire wr_i,
	input wire [PB-1:0] wr_idx_i,
	input wire [7:0] wr_data_i,
	// drain side
	input wire [PB-1:0] rd_idx_i,
	output wire [7:0] rd_data_o,
	output wire rd_valid_o
);
	localparam N = 1 << PB;
	reg [7:0] data_ff [0:N-1];
	reg [N-1:0] valid_ff;
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_ent
			always @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					valid_ff[g] <= 1'b0;
					data_ff[g] <= 8'h00;
				end else if (wr_i && wr_idx_i == g) begin
					// later byte at same slot overwrites earlier one
					valid_ff[g] <= 1'b1;
					data_ff[g] <= wr_data_i;
				end else if (clr_i) begin
					valid_ff[g] <= 1'b0;
				end
			end
		end
	endgenerate
	assign rd_data_o = data_ff[rd_idx_i];
	assign rd_valid_o = valid_ff[rd_idx_i];
endmodule

// >>> verification/sertgt_chk_properties.sv
// port checks for the serial eeprom target
`timescale 1ns/100ps
module sertgt_chk #(
	parameter TWR_CYC = 50
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// serial bus and status
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic wp_i,
	input wire logic busy_o
);
	int busy_cnt_ff;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) busy_cnt_ff <= 0;
		else busy_cnt_ff <= busy_o ? busy_cnt_ff + 1 : 0;
	end
	AST_DRV_ZERO: assert property (sda_oe_o |-> !sda_o)
		else $error("drive value not zero");
	AST_RST_IDLE: assert property ($fell(rst_i) |-> !sda_oe_o && !busy_o)
		else $error("not idle after reset");
	AST_OE_RISE_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
		else $error("drive began with clock high");
	AST_OE_FALL_LOW: assert property ($fell(sda_oe_o) |-> !scl_i)
		else $error("release with clock high");
	AST_OE_HOLD_HIGH: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
		else $error("drive changed in clock high");
	AST_OE_STANDS: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
		else $error("drive too short");
	AST_BUSY_QUIET: assert property (busy_o |-> !sda_oe_o)
		else $error("answer while programming");
	AST_BUSY_FROM_STOP: assert property ($rose(busy_o) |-> scl_i && sda_i)
		else $error("program not started by stop");
	AST_BUSY_LEN: assert property ($fell(busy_o) |->
		busy_cnt_ff >= TWR_CYC && busy_cnt_ff <= TWR_CYC + 2)
		else $error("program length wrong");
endmodule
bind sertgt_top sertgt_chk #(.TWR_CYC(TWR_CYC)) u_chk(.sys_clk_i(sys_clk_i), .rst_i(rst_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
	.busy_o(busy_o));

// >>> verification/sertgt_mst.sv
// two-wire bus master model
`timescale 1ns/100ps
module sertgt_mst (
	// clock
	input wire logic sys_clk_i,
	// serial bus
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	initial begin
		scl_o = 1;
		sda_oe_o = 0;
	end
	// eight clocks a phase, well above the target's minimum
	task hp();
		repeat (8) @(posedge sys_clk_i);
	endtask
	// sampled late in the high phase, target only moves after a fall
	task bit_x(input logic b, output logic r);
		sda_oe_o <= !b;
		hp();
		scl_o <= 1;
		hp();
		r = sda_i;
		scl_o <= 0;
		hp();
	endtask
	task start();
		sda_oe_o <= 0;
		hp();
		scl_o <= 1;
		hp();
		sda_oe_o <= 1;
		hp();
		scl_o <= 0;
		hp();
	endtask
	task stop();
		sda_oe_o <= 1;
		hp();
		scl_o <= 1;
		hp();
		sda_oe_o <= 0;
		hp();
	endtask
	task recover();
		logic r;
		for (int k = 0; k < 9; k++) bit_x(1, r);
	endtask
	task wr_byte(input logic [7:0] v, output logic ack);
		logic r;
		for (int k = 7; k >= 0; k--) bit_x(v[k], r);
		bit_x(1, r);
		ack = !r;
	endtask
	task rd_byte(input logic last, output logic [7:0] v);
		logic r;
		for (int k = 7; k >= 0; k--) begin
			bit_x(1, r);
			v[k] = r;
		end
		bit_x(last, r);
	endtask
endmodule

// >>> verification/tb_top.sv
// testbench for the serial eeprom target
`timescale 1ns/100ps
`include "sertgt_consts.vh"
module tb_top;
	logic sys_clk_i = 0;
	logic rst_i = 1;
	logic wp_i = 0;
	logic scl, m_oe, d_o, d_oe, busy, a;
	wire sda = !(d_oe | m_oe);
	logic [7:0] mem [0:`SERTGT_DEPTH-1];
	logic [7:0] d;
	logic [31:0] seed = 32'h7f52_6a08;
	int errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	always #5 sys_clk_i = !sys_clk_i;
	sertgt_top #(.TWR_CYC(400)) u_dut(.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl),
		.sda_i(sda), .sda_o(d_o), .sda_oe_o(d_oe), .wp_i(wp_i), .busy_o(busy));
	sertgt_mst u_mst(.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task print_verdict();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			print_verdict();
		end
	end
	// retries while programming, n counts the refusals
	task set_addr(input logic [10:0] ad);
		n = 0;
		a = 0;
		while (!a && n < 20) begin
			u_mst.start();
			u_mst.wr_byte({4'ha, ad[10:8], 1'b0}, a);
			if (!a) u_mst.stop();
			if (!a) n++;
		end
		u_mst.wr_byte(ad[7:0], a);
		chk("word address ack", 8'(a), 8'h01);
	endtask
	task wr(input logic [10:0] ad, input int cnt);
		set_addr(ad);
		for (int j = 0; j < cnt; j++) begin
			seed = xs(seed);
			u_mst.wr_byte(seed[7:0], a);
			chk("data ack", 8'(a), 8'h01);
			if (!wp_i) mem[{ad[10:4], 4'(ad[3:0] + j)}] = seed[7:0];
		end
		u_mst.stop();
	endtask
	task rd(input logic [10:0] ad, input int cnt);
		set_addr(ad);
		u_mst.start();
		u_mst.wr_byte({4'ha, ad[10:8], 1'b1}, a);
		chk("read address ack", 8'(a), 8'h01);
		for (int j = 0; j < cnt; j++) begin
			u_mst.rd_byte(j == cnt - 1, d);
			chk("read data", d, mem[11'(ad + j)]);
		end
		u_mst.stop();
	endtask
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 0;
		u_mst.recover();
		u_mst.start();
		u_mst.wr_byte(8'h50, a);
		chk("foreign address ack", 8'(a), 8'h00);
		u_mst.stop();
		wr(11'h000, 2);
		// wraps inside the last page
		wr(11'h7fe, 18);
		chk("poll refused", 8'(n > 0), 8'h01);
		// read rolls from the array end to byte zero
		rd(11'h7f0, 17);
		u_mst.start();
		u_mst.wr_byte(8'ha1, a);
		u_mst.rd_byte(1, d);
		chk("current read", d, mem[1]);
		u_mst.stop();
		wp_i <= 1;
		wr(11'h000, 1);
		// protect must stand until the page has drained
		wait (!busy);
		@(posedge sys_clk_i);
		wp_i <= 0;
		rd(11'h000, 1);
		print_verdict();
	end
endmodule
